// *** verilog/qdsl_device.sv ***
// quad converter digital end: serial frame shifter, channel buffers and output registers
//
// Overview of operation
// - load-high frame loads all outputs together
// - load-low frame writes and loads one channel
// - both load bits zero writes buffer only
// - power-down flag decodes top payload bits
// - power-down kept in buffers, applied on load
// - channel-select field picks channel a to d
// - updates happen at 24th falling clock edge; here outputs change on the third system clock edge after it
// - sync-only systems hold load strobe low
// - load strobe rising edge loads every channel
// - unchanged buffer leaves its output unchanged
// - host fills buffers before raising strobe
// - enable high makes device ignore port
// - host sends frames most significant first
// - byte hosts keep sync low three bytes
// - data valid at falling clock edge
// - early sync rise discards the partial frame
// - loading normal data leaves power-down
// - power-down code zero means high impedance
`timescale 1ns/10ps
`default_nettype none

`include "qdsl_params.svh"

module qdsl_device
  import qdsl_pkg::*;
(
  // system clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  reset,
  // link from the controller
  qdsl_link_if.dev                   link,
  // converter outputs
  output var  logic [3:0][15:0]      chan_code,
  output var  logic [3:0][1:0]       chan_pd_mode,
  output var  logic                  frame_seen
);

  // ----------------------------------------------------------------------
  // link domain: shift register on falling serial clock
  // ----------------------------------------------------------------------

  logic        link_idle;
  logic [4:0]  bit_cnt_q;
  logic [22:0] shift_q;
  logic [23:0] frame_word_q;
  logic        frame_tgl_q;

  // sync high or port released clears the shifter without a clock edge,
  // so an aborted frame can never reach the update logic
  assign link_idle = link.frame_sync_n | link.port_enable;

  // count falling edges from the start of the frame; saturate after 24
  // so extra edges before sync rises do nothing
  always_ff @(negedge link.sclk or posedge link_idle)
  begin
    if (link_idle)
      bit_cnt_q <= 5'h00;
    else if (bit_cnt_q != `QDSL_CNT_DONE)
      bit_cnt_q <= bit_cnt_q + 5'h01;
  end

  // data is taken at the falling edge, first bit is the msb
  always_ff @(negedge link.sclk or posedge link_idle)
  begin
    if (link_idle)
      shift_q <= 23'h00_0000;
    else if (bit_cnt_q != `QDSL_CNT_DONE)
      shift_q <= {shift_q[21:0], link.sdi};
  end

  // the whole word is caught on the 24th falling edge only; this
  // register is left alone until the next complete frame, which keeps
  // it stable while the system side reads it
  always_ff @(negedge link.sclk)
  begin
    if (!link_idle && bit_cnt_q == `QDSL_LAST_BIT)
      frame_word_q <= {shift_q, link.sdi};
  end

  // toggle announces a complete frame to the system side
  always_ff @(negedge link.sclk or posedge reset)
  begin
    if (reset)
      frame_tgl_q <= 1'b0;
    else if (!link_idle && bit_cnt_q == `QDSL_LAST_BIT)
      frame_tgl_q <= ~frame_tgl_q;
  end

  // ----------------------------------------------------------------------
  // crossings into the system clock
  // ----------------------------------------------------------------------

  logic tgl_s1_q;
  logic tgl_s2_q;
  logic tgl_s3_q;
  logic ldst_s1_q;
  logic ldst_s2_q;
  logic ldst_s3_q;
  logic frame_evt;
  logic strobe_rise;

  // two flops per crossing, a third for the edge
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      tgl_s1_q  <= 1'b0;
      tgl_s2_q  <= 1'b0;
      tgl_s3_q  <= 1'b0;
      ldst_s1_q <= 1'b0;
      ldst_s2_q <= 1'b0;
      ldst_s3_q <= 1'b0;
    end
    else
    begin
      tgl_s1_q  <= frame_tgl_q;
      tgl_s2_q  <= tgl_s1_q;
      tgl_s3_q  <= tgl_s2_q;
      ldst_s1_q <= link.async_load_strobe;
      ldst_s2_q <= ldst_s1_q;
      ldst_s3_q <= ldst_s2_q;
    end
  end

  assign frame_evt   = tgl_s2_q ^ tgl_s3_q;
  // a strobe held low forever never loads anything
  assign strobe_rise = ldst_s2_q & ~ldst_s3_q;

  // ----------------------------------------------------------------------
  // frame decode
  // ----------------------------------------------------------------------

  logic        addr_hit;
  logic        do_frame;
  logic        load_all;
  logic [1:0]  chan_sel;
  logic [1:0]  pay_mode;
  qdsl_chan_s  new_entry;

  assign addr_hit = {frame_word_q[`QDSL_ADDR_HI], frame_word_q[`QDSL_ADDR_LO]}
                    == `QDSL_DEV_ADDR;
  assign do_frame = frame_evt & addr_hit;
  // the unused frame bit is never looked at
  assign chan_sel = frame_word_q[`QDSL_CHAN_HI:`QDSL_CHAN_LO];
  assign pay_mode = {frame_word_q[`QDSL_PAY_TOP], frame_word_q[`QDSL_PAY_SECOND]};

  // a frame load-all and a strobe edge in the same cycle merge into one
  assign load_all = strobe_rise | (do_frame & frame_word_q[`QDSL_LOAD_HIGH]);

  // power-down is stored as data: mode over payload; code 00 with the
  // flag set is high impedance, plain data carries mode none
  always_comb
  begin
    new_entry.code = frame_word_q[`QDSL_PAY_HI:`QDSL_PAY_LO];
    if (!frame_word_q[`QDSL_PD_FLAG])
      new_entry.mode = QDSL_PD_NONE;
    else if (pay_mode == QDSL_PD_NONE)
      new_entry.mode = QDSL_PD_HIZ;
    else
      new_entry.mode = pay_mode;
  end

  // ----------------------------------------------------------------------
  // per channel buffer and output register
  // ----------------------------------------------------------------------

  genvar ch;
  generate
    for (ch = 0; ch < `QDSL_CHANNELS; ch++)
    begin : g_chan
      logic       write_buf;
      logic       load_one;
      qdsl_chan_s buf_q;
      qdsl_chan_s buf_d;

      assign write_buf = do_frame && (chan_sel == 2'(ch));
      // single load only when load-high is clear
      assign load_one  = write_buf & ~frame_word_q[`QDSL_LOAD_HIGH]
                         & frame_word_q[`QDSL_LOAD_LOW];
      // new content as seen by a load in the same cycle
      assign buf_d     = write_buf ? new_entry : buf_q;

      // temporary buffer; written by every addressed frame whose channel field selects this channel
      always_ff @(posedge clk_sys)
      begin
        if (reset)
          buf_q <= '{mode: `QDSL_MODE_RESET, code: `QDSL_CODE_RESET};
        else if (write_buf)
          buf_q <= new_entry;
      end

      // output register; an untouched buffer equals the output, so a
      // load leaves that channel where it was
      always_ff @(posedge clk_sys)
      begin
        if (reset)
        begin
          chan_code[ch]    <= `QDSL_CODE_RESET;
          chan_pd_mode[ch] <= `QDSL_MODE_RESET;
        end
        else if (load_all || load_one)
        begin
          chan_code[ch]    <= buf_d.code;
          chan_pd_mode[ch] <= buf_d.mode;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // frame seen pulse for observation
  // ----------------------------------------------------------------------

  // one cycle per accepted frame, from a flop
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      frame_seen <= 1'b0;
    else
      frame_seen <= do_frame;
  end

endmodule

`default_nettype wire

// *** verilog/qdsl_params.svh ***
// constants for the quad converter serial load link: frame layout, codes, timing, host map
`ifndef QDSL_PARAMS_SVH
`define QDSL_PARAMS_SVH

// ----------------------------------------------------------------------
// frame layout, first bit sent is bit 23
// ----------------------------------------------------------------------
`define QDSL_FRAME_BITS     24
`define QDSL_LAST_BIT       5'h17
`define QDSL_CNT_DONE       5'h18
`define QDSL_ADDR_HI        23
`define QDSL_ADDR_LO        22
`define QDSL_LOAD_HIGH      21
`define QDSL_LOAD_LOW       20
`define QDSL_UNUSED_BIT     19
`define QDSL_CHAN_HI        18
`define QDSL_CHAN_LO        17
`define QDSL_PD_FLAG        16
`define QDSL_PAY_HI         15
`define QDSL_PAY_LO         0
`define QDSL_PAY_TOP        15
`define QDSL_PAY_SECOND     14

// ----------------------------------------------------------------------
// channel and reset values
// ----------------------------------------------------------------------
`define QDSL_CHANNELS       4
`define QDSL_DEV_ADDR       2'h0
`define QDSL_CODE_RESET     16'h0000
`define QDSL_MODE_RESET     2'h0

// ----------------------------------------------------------------------
// timing: link period, system period, derived half period
// ----------------------------------------------------------------------
`define QDSL_LINK_PERIOD_NS 48
`define QDSL_SYS_PERIOD_NS  4
`define QDSL_HALF_CYCLES    (`QDSL_LINK_PERIOD_NS / `QDSL_SYS_PERIOD_NS / 2)
`define QDSL_HALF_LAST      4'((`QDSL_HALF_CYCLES) - 1)

// ----------------------------------------------------------------------
// host command port map
// ----------------------------------------------------------------------
`define QDSL_REG_FRAME      8'h00
`define QDSL_REG_CTRL       8'h04
`define QDSL_REG_STATUS     8'h08
`define QDSL_CTRL_STROBE    0
`define QDSL_CTRL_RELEASE   1
`define QDSL_STAT_BUSY      0
`define QDSL_STAT_STROBE    1
`define QDSL_STAT_RELEASE   2

`endif

// *** verilog/qdsl_pkg.sv ***
// types shared by both ends of the quad converter serial load link
`default_nettype none

package qdsl_pkg;

  // power-down mode held with each channel
  typedef enum logic [1:0] {
    QDSL_PD_NONE = 2'h0,
    QDSL_PD_1K   = 2'h1,
    QDSL_PD_100K = 2'h2,
    QDSL_PD_HIZ  = 2'h3
  } qdsl_pd_e;

  // one channel entry: mode over code
  typedef struct packed {
    logic [1:0]  mode;
    logic [15:0] code;
  } qdsl_chan_s;

  // host frame sender states
  typedef enum logic [4:0] {
    QDSL_ST_IDLE  = 5'b0_0001,
    QDSL_ST_SETUP = 5'b0_0010,
    QDSL_ST_HIGH  = 5'b0_0100,
    QDSL_ST_LOW   = 5'b0_1000,
    QDSL_ST_DONE  = 5'b1_0000
  } qdsl_host_state_e;

endpackage

`default_nettype wire

// *** verilog/qdsl_link_if.sv ***
// link wires between the controller and the quad converter
`timescale 1ns/10ps
`default_nettype none

interface qdsl_link_if;
  logic sclk;               // serial clock, idles low
  logic frame_sync_n;       // frame sync, low across a frame
  logic sdi;                // serial data, valid at falling sclk
  logic port_enable;        // high makes the converter ignore the port
  logic async_load_strobe;  // rising edge loads all channels

  modport host (
    output sclk,
    output frame_sync_n,
    output sdi,
    output port_enable,
    output async_load_strobe
  );

  modport dev (
    input sclk,
    input frame_sync_n,
    input sdi,
    input port_enable,
    input async_load_strobe
  );
endinterface

`default_nettype wire

// *** verilog/qdsl_host.sv ***
// controller end: command port registers and 24-bit frame sender
`timescale 1ns/10ps
`default_nettype none

`include "qdsl_params.svh"

module qdsl_host
  import qdsl_pkg::*;
(
  // system clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // command port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output var  logic [31:0] rdata,
  // link to the converter
  qdsl_link_if.host        link
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------

  qdsl_host_state_e state_q;
  logic [3:0]       half_q;
  logic [4:0]       bit_q;
  logic [23:0]      shift_q;
  logic [23:0]      last_frame_q;
  logic             half_done;
  logic             busy;
  logic             start;

  assign half_done = (half_q == `QDSL_HALF_LAST);
  assign busy      = (state_q != QDSL_ST_IDLE);
  // a frame write while busy is dropped
  assign start     = wr && (addr == `QDSL_REG_FRAME) && !busy;

  // ----------------------------------------------------------------------
  // control pins written by software
  // ----------------------------------------------------------------------

  // strobe stays low unless software raises it; port release parks the
  // converter so the wires can be shared
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      link.async_load_strobe <= 1'b0;
      link.port_enable       <= 1'b0;
    end
    else if (wr && addr == `QDSL_REG_CTRL)
    begin
      link.async_load_strobe <= wdata[`QDSL_CTRL_STROBE];
      link.port_enable       <= wdata[`QDSL_CTRL_RELEASE];
    end
  end

  // ----------------------------------------------------------------------
  // half period timer, counts only while a frame is under way
  // ----------------------------------------------------------------------

  always_ff @(posedge clk_sys)
  begin
    if (reset || !busy || half_done)
      half_q <= 4'h0;
    else
      half_q <= half_q + 4'h1;
  end

  // ----------------------------------------------------------------------
  // frame sender: sync low for all 24 bits, data changes on the rising
  // edge so it is steady at the falling edge
  // ----------------------------------------------------------------------

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state_q           <= QDSL_ST_IDLE;
      link.sclk         <= 1'b0;
      link.frame_sync_n <= 1'b1;
      link.sdi          <= 1'b0;
      bit_q             <= 5'h00;
      shift_q           <= 24'h00_0000;
      last_frame_q      <= 24'h00_0000;
    end
    else
    begin
      unique case (state_q)
        QDSL_ST_IDLE:
        begin
          if (start)
          begin
            shift_q           <= wdata[23:0];
            last_frame_q      <= wdata[23:0];
            bit_q             <= 5'h00;
            link.frame_sync_n <= 1'b0;
            state_q           <= QDSL_ST_SETUP;
          end
        end
        QDSL_ST_SETUP:
        begin
          if (half_done)
          begin
            link.sclk <= 1'b1;
            link.sdi  <= shift_q[23];
            state_q   <= QDSL_ST_HIGH;
          end
        end
        QDSL_ST_HIGH:
        begin
          if (half_done)
          begin
            link.sclk <= 1'b0;
            state_q   <= QDSL_ST_LOW;
          end
        end
        QDSL_ST_LOW:
        begin
          if (half_done)
          begin
            if (bit_q == `QDSL_LAST_BIT)
            begin
              link.frame_sync_n <= 1'b1;
              state_q           <= QDSL_ST_DONE;
            end
            else
            begin
              bit_q     <= bit_q + 5'h01;
              shift_q   <= {shift_q[22:0], 1'b0};
              link.sclk <= 1'b1;
              link.sdi  <= shift_q[22];
              state_q   <= QDSL_ST_HIGH;
            end
          end
        end
        QDSL_ST_DONE:
        begin
          // sync stays high one half period before the next frame
          if (half_done)
            state_q <= QDSL_ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // read port, data one cycle after the strobe
  // ----------------------------------------------------------------------

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      rdata <= 32'h0000_0000;
    else if (rd)
    begin
      unique case (addr)
        `QDSL_REG_FRAME:  rdata <= {8'h00, last_frame_q};
        `QDSL_REG_CTRL:   rdata <= {30'h0000_0000, link.port_enable,
                                    link.async_load_strobe};
        `QDSL_REG_STATUS: rdata <= {29'h0000_0000, link.port_enable,
                                    link.async_load_strobe, busy};
        default:          rdata <= 32'h0000_0000;
      endcase
    end
    else
      rdata <= 32'h0000_0000;
  end

endmodule

`default_nettype wire

// *** sim/qdsl_link_sva.sv ***
// checker on the serial load link wires and the converter outputs
`timescale 1ns/10ps
`default_nettype none

module qdsl_link_sva (
  // clock and reset
  input  wire logic            clk_sys,
  input  wire logic            reset,
  // link wires
  input  wire logic            sclk,
  input  wire logic            frame_sync_n,
  input  wire logic            sdi,
  input  wire logic            port_enable,
  input  wire logic            async_load_strobe,
  // converter outputs
  input  wire logic [3:0][15:0] chan_code,
  input  wire logic [3:0][1:0]  chan_pd_mode,
  input  wire logic            frame_seen
);
  // ----------------------------------------------------------------
  // helper state
  // ----------------------------------------------------------------
  logic        sclk_q;
  logic        strb_q;
  logic [4:0]  fall_q;
  logic [7:0]  quiet_q;
  logic [22:0] sh_q;
  wire         fell_w = sclk_q && !sclk;
  wire         last_w = fell_w && !frame_sync_n && (fall_q == 5'h17);

  // edge history; host makes sclk from a flop, so the system clock sees every phase
  always_ff @(posedge clk_sys)
  begin
    sclk_q <= sclk;
    strb_q <= async_load_strobe;
  end

  // falls counted inside a frame
  always_ff @(posedge clk_sys)
  begin
    if (reset || frame_sync_n)
      fall_q <= 5'h00;
    else if (fell_w)
      fall_q <= fall_q + 5'h01;
  end

  // bits seen so far, for the address field at the last fall
  always_ff @(posedge clk_sys)
  begin
    if (fell_w)
      sh_q <= {sh_q[21:0], sdi};
  end

  // cycles since the last listened frame end, any address, or strobe rise; saturates so it never wraps
  always_ff @(posedge clk_sys)
  begin
    if (reset || (last_w && !port_enable) || (async_load_strobe && !strb_q))
      quiet_q <= 8'h00;
    else if (quiet_q != 8'hff)
      quiet_q <= quiet_q + 8'h01;
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence hi_phase;
    sclk [*6] ##1 !sclk;
  endsequence

  sequence lead_in;
    !sclk [*6] ##1 sclk;
  endsequence

  idle_clk_low_a: assert property (frame_sync_n |-> !sclk)
    else $error("sclk not low outside a frame");
  clk_high_a: assert property ($rose(sclk) |-> hi_phase)
    else $error("sclk high phase wrong length");
  lead_in_a: assert property ($fell(frame_sync_n) |-> lead_in)
    else $error("first sclk rise not six cycles after sync");
  data_hold_a: assert property ($rose(sclk) |=> $stable(sdi) [*5])
    else $error("sdi moved while sclk high");
  frame_len_a: assert property ($rose(frame_sync_n) |-> fall_q == 5'h18)
    else $error("frame not 24 falls long");
  seen_after_a: assert property (last_w && !port_enable && sh_q[22:21] == 2'h0
                                 |-> ##[1:6] frame_seen)
    else $error("accepted frame gave no frame_seen");
  seen_bound_a: assert property (frame_seen |-> quiet_q <= 8'h07)
    else $error("frame_seen without a listened frame end");
  addr_drop_a: assert property (last_w && sh_q[22:21] != 2'h0 |=> !frame_seen [*8])
    else $error("frame for another address accepted");
  seen_pulse_a: assert property (frame_seen |=> !frame_seen)
    else $error("frame_seen longer than one cycle");
  out_hold_a: assert property (quiet_q > 8'h08
                               |-> $stable(chan_code) && $stable(chan_pd_mode))
    else $error("outputs moved with no load cause");
endmodule

`default_nettype wire

// *** sim/test_quad_dac_serial_load_control.sv ***
// bench: controller and converter joined by the link, plus a hand-driven second link
`timescale 1ns/10ps
`default_nettype none

`include "qdsl_params.svh"

module test_quad_dac_serial_load_control;
  logic             clk_sys = 1'b0;
  logic             reset = 1'b1;
  logic [7:0]       addr = 8'h00;
  logic [31:0]      wdata = 32'h0000_0000;
  logic             wr = 1'b0;
  logic             rd = 1'b0;
  logic [31:0]      rdata;
  logic [3:0][15:0] chan_code;
  logic [3:0][1:0]  chan_pd_mode;
  logic             frame_seen;
  logic [3:0][15:0] code_b;
  logic [3:0][1:0]  mode_b;
  logic [17:0]      buf_m [4] = '{default: 18'h0_0000};
  logic [17:0]      out_m [4] = '{default: 18'h0_0000};
  logic [23:0]      last_f;
  logic [23:0]      mon_sh;
  logic [7:0]       mon_cnt;
  logic             mon_on = 1'b0;
  logic             en_q = 1'b0;
  logic [31:0]      r;
  logic [31:0]      v;
  int               n_errors = 0;
  int               cmp_count = 0;
  int               seed = 87326;

  qdsl_link_if lnk ();
  qdsl_link_if lnk_b ();

  // ----------------------------------------------------------------
  // design ends and checker
  // ----------------------------------------------------------------
  qdsl_host u_qdsl_host (.clk_sys(clk_sys), .reset(reset), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .link(lnk.host));
  qdsl_device u_qdsl_device (.clk_sys(clk_sys), .reset(reset), .link(lnk.dev),
    .chan_code(chan_code), .chan_pd_mode(chan_pd_mode), .frame_seen(frame_seen));
  // second converter, fed by the bench to break the framing on purpose
  qdsl_device u_qdsl_device_b (.clk_sys(clk_sys), .reset(reset), .link(lnk_b.dev),
    .chan_code(code_b), .chan_pd_mode(mode_b), .frame_seen());
  qdsl_link_sva u_qdsl_link_sva (.clk_sys(clk_sys), .reset(reset), .sclk(lnk.sclk),
    .frame_sync_n(lnk.frame_sync_n), .sdi(lnk.sdi), .port_enable(lnk.port_enable),
    .async_load_strobe(lnk.async_load_strobe), .chan_code(chan_code),
    .chan_pd_mode(chan_pd_mode), .frame_seen(frame_seen));

  // system clock
  always #2 clk_sys = ~clk_sys;

  // ----------------------------------------------------------------
  // compare, verdict, bus cycles
  // ----------------------------------------------------------------
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    if (n_errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic host_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe edge
  task automatic host_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // ----------------------------------------------------------------
  // expected converter state
  // ----------------------------------------------------------------
  function automatic logic [23:0] frm(input logic [1:0] ld, input logic [1:0] ch,
                                      input logic pd, input logic [15:0] p);
    return {2'h0, ld, 1'b0, ch, pd, p};
  endfunction

  function automatic logic [17:0] entry(input logic [23:0] f);
    logic [1:0] m;
    m = (f[15:14] == 2'h0) ? 2'h3 : f[15:14];
    return {f[16] ? m : 2'h0, f[15:0]};
  endfunction

  task automatic apply(input logic [23:0] f);
    if (f[23:22] == 2'h0 && !en_q)
    begin
      buf_m[f[18:17]] = entry(f);
      if (f[21])
        out_m = buf_m;
      else if (f[20])
        out_m[f[18:17]] = buf_m[f[18:17]];
    end
  endtask

  task automatic check_outs();
    for (int k = 0; k < 4; k++)
      check_word({14'h0, chan_pd_mode[k], chan_code[k]}, {14'h0, out_m[k]});
  endtask

  // one frame through the command port, waited out on the busy bit
  task automatic send(input logic [23:0] f);
    int i;
    host_write(`QDSL_REG_FRAME, {8'h00, f});
    last_f = f;
    // a second frame while busy must be dropped, never sent or stored
    host_write(`QDSL_REG_FRAME, {8'h00, ~f});
    repeat (2) @(posedge clk_sys);
    for (i = 0; i < 400; i++)
    begin
      host_read(`QDSL_REG_STATUS, v);
      if (v[0] === 1'b0)
        break;
    end
    if (i == 400)
    begin
      n_errors++;
      test_done();
    end
    apply(f);
    host_read(`QDSL_REG_FRAME, v);
    check_word(v, {8'h00, f});
    repeat (4) @(posedge clk_sys);
    check_outs();
  endtask

  // strobe held several cycles each way so its edge is seen
  task automatic strobe();
    host_write(`QDSL_REG_CTRL, {30'h0, en_q, 1'b1});
    host_read(`QDSL_REG_STATUS, v);
    check_word(v & 32'h0000_0002, 32'h0000_0002);
    repeat (2) @(posedge clk_sys);
    host_write(`QDSL_REG_CTRL, {30'h0, en_q, 1'b0});
    out_m = buf_m;
    repeat (6) @(posedge clk_sys);
    check_outs();
  endtask

  // hand-driven frame of n bits; 48 ns link period off the system clock phase
  task automatic bang(input logic [23:0] f, input int n);
    lnk_b.frame_sync_n = 1'b0;
    #5;
    for (int k = 23; k > 23 - n; k--)
    begin
      #24 lnk_b.sclk = 1'b1;
      lnk_b.sdi = f[k];
      #24 lnk_b.sclk = 1'b0;
    end
    #24 lnk_b.frame_sync_n = 1'b1;
    lnk_b.sdi = ~f[24 - n];
    repeat (12) @(posedge clk_sys);
  endtask

  // wire monitor: bit order and count of every frame on the joined link
  always @(negedge lnk.sclk)
    if (!lnk.frame_sync_n)
    begin
      mon_sh = {mon_sh[22:0], lnk.sdi};
      mon_cnt = mon_cnt + 8'h01;
    end
  always @(negedge lnk.frame_sync_n)
    mon_cnt = 8'h00;
  always @(posedge lnk.frame_sync_n)
    if (mon_on)
      check_word({mon_cnt, mon_sh}, {8'h18, last_f});

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    lnk_b.sclk = 1'b0;
    lnk_b.frame_sync_n = 1'b1;
    lnk_b.sdi = 1'b0;
    lnk_b.port_enable = 1'b0;
    lnk_b.async_load_strobe = 1'b0;
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    mon_on = 1'b1;
    // buffers only, then strobes, one with a single rewritten buffer
    for (int c = 0; c < 4; c++)
    begin
      r = $random(seed);
      send(frm(2'h0, 2'(c), 1'b0, r[15:0]));
    end
    strobe();
    send(frm(2'h0, 2'h1, 1'b0, 16'h1234));
    strobe();
    // sequential power-down, every mode code, then leave it with data
    for (int c = 0; c < 4; c++)
      send(frm(2'h1, 2'(c), 1'b1, {2'(c), 14'h2aaa}));
    send(frm(2'h1, 2'h1, 1'b0, 16'h0f0f));
    // power-down held in buffers, applied by a load-all frame
    for (int c = 0; c < 4; c++)
      send(frm((c == 3) ? 2'h2 : 2'h0, 2'(c), 1'b1, (c < 2) ? 16'h4000 : 16'h8000));
    // port ignored while enable high; status shows it; unmapped reads zero
    en_q = 1'b1;
    host_write(`QDSL_REG_CTRL, 32'h0000_0002);
    send(frm(2'h1, 2'h0, 1'b0, 16'hbeef));
    host_read(`QDSL_REG_STATUS, v);
    check_word(v & 32'h0000_0004, 32'h0000_0004);
    host_read(`QDSL_REG_CTRL, v);
    check_word(v, 32'h0000_0002);
    en_q = 1'b0;
    host_write(`QDSL_REG_CTRL, 32'h0000_0000);
    host_read(8'h0c, v);
    check_word(v, 32'h0000_0000);
    send(frm(2'h3, 2'h2, 1'b0, 16'h5a5a) | 24'hc0_0000);
    // random frames, load bits, channels and flags, strobes among them
    repeat (12)
    begin
      r = $random(seed);
      send({(r[31:28] == 4'h0) ? 2'h1 : 2'h0, r[27:26], r[25], r[24:23], r[22], r[15:0]});
      if (r[20])
        strobe();
    end
    // broken framing on the second link: early sync rise discards the frame
    bang(frm(2'h1, 2'h2, 1'b0, 16'ha5c3), 24);
    check_word({16'h0, code_b[2]}, {16'h0, 16'ha5c3});
    bang(frm(2'h1, 2'h2, 1'b0, 16'h3c5a), 23);
    check_word({14'h0, mode_b[2], code_b[2]}, {14'h0, 2'h0, 16'ha5c3});
    bang(frm(2'h1, 2'h2, 1'b0, 16'h3c5a), 24);
    check_word({16'h0, code_b[2]}, {16'h0, 16'h3c5a});
    test_done();
  end
endmodule

`default_nettype wire
